// ---- tb_timer_based_pwm_output.sv ----
// Purpose: self-checking bench for the timer based pwm output
// Assumes: apb master, load model on the pin
// Notes: reads and pwm periods are queued and checked by a monitor
`timescale 1ns/1ns
module tb_timer_based_pwm_output;
    import tbpwm_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, pin_o, pin_oe, level, meas_valid, last_err;
    logic [15:0] high_cnt, per_cnt;
    logic [32:0] rd_q[$];
    logic [31:0] pw_q[$];
    int n_fail = 0;
    int checks_done = 0;
    int n_meas = 0;
    always #4 ref_clk = ~ref_clk;
    tbpwm_top i_dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwm_output_pin_o(pin_o), .pwm_output_pin_oe(pin_oe));
    tbpwm_load i_load (.ref_clk(ref_clk), .resetn(resetn), .pin_o(pin_o), .pin_oe(pin_oe),
        .level(level), .meas_valid(meas_valid), .high_cnt(high_cnt), .per_cnt(per_cnt));
    // ----------------------------------------------------------------
    // compare and report
    // ----------------------------------------------------------------
    task automatic report(input string what, input logic [32:0] exp, input logic [32:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : report
    task automatic cmp_read(input logic [32:0] exp, input logic [32:0] got);
        report("read", exp, got);
    endtask : cmp_read
    task automatic cmp_pwm(input logic [31:0] exp, input logic [31:0] got);
        report("high and period", {1'b0, exp}, {1'b0, got});
    endtask : cmp_pwm
    task automatic cmp_pin(input string what, input logic exp, input logic got);
        report(what, {32'h0, exp}, {32'h0, got});
    endtask : cmp_pin
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    task automatic timeout;
        n_fail++;
        tally_and_finish();
    endtask : timeout
    always @(posedge ref_clk)
    begin
        if (psel && penable && pready && !pwrite && rd_q.size() > 0)
            cmp_read(rd_q.pop_front(), {pslverr, prdata});
        if (meas_valid === 1'b1)
            n_meas++;
        if (meas_valid === 1'b1 && pw_q.size() > 0)
            cmp_pwm(pw_q.pop_front(), {high_cnt, per_cnt});
    end
    // ----------------------------------------------------------------
    // bus and scenario tasks
    // ----------------------------------------------------------------
    task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= is_wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        t = 0;
        do
        begin
            @(posedge ref_clk);
            t++;
        end
        while (pready !== 1'b1 && t < 50);
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (t >= 50)
            timeout();
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        rd_q.push_back({25'h0000000, d});
        apb(1'b0, a, 32'h00000000);
    endtask : rd
    task automatic wait_meas(input int n);
        int t;
        int target;
        target = n_meas + n;
        t = 0;
        while (n_meas < target && t < 20000)
        begin
            @(posedge ref_clk);
            t++;
        end
        if (t >= 20000)
            timeout();
    endtask : wait_meas
    task automatic hold_level(input logic v, input int settle, input int n);
        int bad;
        bad = 0;
        repeat (settle) @(posedge ref_clk);
        repeat (n)
        begin
            @(posedge ref_clk);
            if (level !== v)
                bad++;
        end
        report("pin level", 33'h0, 33'(bad));
    endtask : hold_level
    task automatic setup(input logic [7:0] lim, input logic [9:0] d, input logic [1:0] ps,
        input logic [3:0] post);
        wr(OFF_UNIT_CONTROL, 8'h00);
        wr(OFF_PERIOD_TIMER_CONTROL, 8'h00);
        wr(OFF_PERIOD_TIMER_COUNT, 8'h00);
        wr(OFF_PERIOD_LIMIT, lim);
        wr(OFF_DUTY_PENDING_UPPER, d[9:2]);
        wr(OFF_PIN_DIRECTION, 8'h00);
        wr(OFF_PERIOD_TIMER_CONTROL, {1'b0, post, 1'b1, ps});
        wr(OFF_UNIT_CONTROL, {2'b00, d[1:0], 4'hC});
    endtask : setup
    task automatic run_pwm(input logic [7:0] lim, input logic [9:0] d, input logic [1:0] ps,
        input logic [3:0] post);
        int k;
        logic [15:0] p;
        logic [15:0] h;
        k = ps[1] ? 64 : (ps[0] ? 16 : 4);
        p = 16'((int'(lim) + 1) * k);
        h = 16'(int'(d) * k / 4);
        setup(lim, d, ps, post);
        wait_meas(2);
        pw_q.push_back({h, p});
        pw_q.push_back({h, p});
        wait_meas(2);
        rd(OFF_DUTY_ACTIVE_UPPER, d[9:2]);
    endtask : run_pwm
    initial
    begin
        logic [9:0] d;
        logic [7:0] lim;
        void'($urandom(70));
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(OFF_PERIOD_TIMER_COUNT, RST_BYTE);
        rd(OFF_PERIOD_LIMIT, RST_LIMIT);
        rd(OFF_PERIOD_TIMER_CONTROL, RST_BYTE);
        rd(OFF_DUTY_PENDING_UPPER, RST_BYTE);
        rd(OFF_DUTY_ACTIVE_UPPER, RST_BYTE);
        rd(OFF_UNIT_CONTROL, RST_BYTE);
        rd(OFF_PIN_DIRECTION, RST_DIRECTION);
        wr(OFF_PERIOD_TIMER_CONTROL, 8'hFF);
        rd(OFF_PERIOD_TIMER_CONTROL, 8'h7F);
        wr(OFF_UNIT_CONTROL, 8'hFF);
        rd(OFF_UNIT_CONTROL, 8'h3F);
        cmp_pin("pin enable", 1'b0, pin_oe);
        wr(8'h1C, 8'h55);
        cmp_pin("slave error", 1'b1, last_err);
        run_pwm(8'h00, 10'd2, 2'd0, 4'h0);
        for (int i = 0; i < 4; i++)
        begin
            lim = 8'($urandom_range(1, 12));
            d = 10'($urandom_range(1, 4 * lim + 3));
            if (i >= 2)
                d = {8'($urandom_range(1, lim)), 2'b00};
            run_pwm(lim, d, i[1:0], 4'($urandom));
        end
        setup(8'h0F, 10'd40, 2'd0, 4'h0);
        wait_meas(2);
        wr(OFF_DUTY_PENDING_UPPER, 8'h05);
        wr(OFF_UNIT_CONTROL, 8'h3C);
        pw_q.push_back({16'd40, 16'd64});
        pw_q.push_back({16'd23, 16'd64});
        wait_meas(2);
        wr(OFF_DUTY_ACTIVE_UPPER, 8'hAA);
        rd(OFF_DUTY_ACTIVE_UPPER, 8'h05);
        wr(OFF_PIN_DIRECTION, 8'h01);
        repeat (3) @(posedge ref_clk);
        cmp_pin("pin enable", 1'b0, pin_oe);
        hold_level(1'b0, 0, 100);
        setup(8'h03, 10'd20, 2'd0, 4'h0);
        hold_level(1'b1, 40, 64);
        wr(OFF_UNIT_CONTROL, 8'h00);
        hold_level(1'b0, 3, 40);
        cmp_pin("pin value", 1'b0, pin_o);
        setup(8'h03, 10'd0, 2'd0, 4'h0);
        hold_level(1'b0, 40, 64);
        tally_and_finish();
    end
endmodule : tb_timer_based_pwm_output

// ---- tbpwm_load.sv ----
// Purpose: external load on the pwm pin, measures high time and period
// Assumes: the pin has a pull-down, so it reads low while not driven
// Notes: reports one measurement at each rising edge of the pin level
`timescale 1ns/1ns
module tbpwm_load
(
    input wire logic ref_clk, // core clock
    input wire logic resetn, // async reset, low active
    input wire logic pin_o, // pin value from the block
    input wire logic pin_oe, // pin enable from the block
    output logic level, // pin level at the load
    output logic meas_valid, // one cycle, a period has ended
    output logic [15:0] high_cnt, // high clocks of the last period
    output logic [15:0] per_cnt // clocks of the last period
);
    logic [15:0] hi_reg;
    logic [15:0] per_reg;
    logic prev_reg;
    // pull-down when the block releases the pin
    assign level = pin_oe ? pin_o : 1'b0;
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hi_reg <= 16'h0000;
            per_reg <= 16'h0000;
            prev_reg <= 1'b0;
            meas_valid <= 1'b0;
            high_cnt <= 16'h0000;
            per_cnt <= 16'h0000;
        end
        else
        begin
            prev_reg <= level;
            meas_valid <= level && !prev_reg;
            if (level && !prev_reg)
            begin
                high_cnt <= hi_reg;
                per_cnt <= per_reg;
                hi_reg <= 16'h0001;
                per_reg <= 16'h0001;
            end
            else
            begin
                hi_reg <= hi_reg + {15'h0000, level};
                per_reg <= per_reg + 16'h0001;
            end
        end
    end
endmodule : tbpwm_load

// ---- tbpwm_pkg.sv ----
// Purpose: constants for the timer based pwm output block
// Assumes: apb register map with one byte register per aligned word
// Notes: offsets are byte addresses
package tbpwm_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_PERIOD_TIMER_COUNT = 8'h00;
    localparam logic [7:0] OFF_PERIOD_LIMIT = 8'h04;
    localparam logic [7:0] OFF_PERIOD_TIMER_CONTROL = 8'h08;
    localparam logic [7:0] OFF_DUTY_PENDING_UPPER = 8'h0C;
    localparam logic [7:0] OFF_DUTY_ACTIVE_UPPER = 8'h10;
    localparam logic [7:0] OFF_UNIT_CONTROL = 8'h14;
    localparam logic [7:0] OFF_PIN_DIRECTION = 8'h18;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int TIMER_RUN_BIT = 2;
    localparam int PRESCALE_LSB = 0;
    localparam int POSTSCALE_LSB = 3;
    localparam int DUTY_LOW_LSB = 4;
    localparam int MODE_LSB = 0;
    // ----------------------------------------------------------------
    // reset values and pwm mode match
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_LIMIT = 8'hFF;
    localparam logic [7:0] RST_DIRECTION = 8'h01;
    localparam logic [3:0] PWM_MODE_MASK = 4'hC;
    localparam logic [3:0] PWM_MODE_VALUE = 4'hC;
    // ----------------------------------------------------------------
    // prescaler selections and their terminal counts
    // ----------------------------------------------------------------
    localparam logic [1:0] PRESCALE_DIV1 = 2'h0;
    localparam logic [1:0] PRESCALE_DIV4 = 2'h1;
    localparam logic [5:0] PRESCALE_TOP1 = 6'h03;
    localparam logic [5:0] PRESCALE_TOP4 = 6'h0F;
    localparam logic [5:0] PRESCALE_TOP16 = 6'h3F;
    localparam int QCLK_CYCLES = 4;
endpackage : tbpwm_pkg

// ---- tbpwm_prescaler.sv ----
// Purpose: prescaler producing timer increment ticks and the fine phase bits
// Assumes: one clock; counts core clocks, four to one quarter-phase cycle
// Notes: fine bits come from the quarter-phase clock at divide by one
`timescale 1ns/1ns
module tbpwm_prescaler
    import tbpwm_pkg::*;
(
    input wire logic ref_clk, // core clock
    input wire logic resetn, // async reset, low active
    input wire logic run, // timer running
    input wire logic [1:0] sel, // prescale selection
    output logic tick, // one cycle increment pulse
    output logic [1:0] fine // two low-order compare bits
);
    logic [5:0] pre_reg;
    logic [5:0] top;

    always_comb
    begin
        if (sel == PRESCALE_DIV1)
            top = PRESCALE_TOP1;
        else if (sel == PRESCALE_DIV4)
            top = PRESCALE_TOP4;
        else
            top = PRESCALE_TOP16;
    end

    // ----------------------------------------------------------------
    // counters
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            pre_reg <= 6'h00;
        else if (!run || pre_reg >= top)
            pre_reg <= 6'h00;
        else
            pre_reg <= pre_reg + 6'h01;
    end

    // low two bits are the quarter phase; one increment per 4, 16 or 64 core clocks
    assign tick = run && (pre_reg >= top);
    // fine bits step once per prescaled quarter cycle
    always_comb
    begin
        if (sel == PRESCALE_DIV1)
            fine = pre_reg[1:0];
        else if (sel == PRESCALE_DIV4)
            fine = pre_reg[3:2];
        else
            fine = pre_reg[5:4];
    end
endmodule : tbpwm_prescaler

// ---- tbpwm_top.sv ----
// Purpose: pwm output of a capture/compare unit driven by an 8-bit period timer
// Assumes: apb slave, 32-bit data, registers hold a byte in the low lane
// Notes: zero wait state apb; pin driven only when direction bit is clear
`timescale 1ns/1ns
// Behaviour
// - timer equal to period limit clears on next increment, ending the period
// - pin goes high at period start unless duty is zero
// - pending duty copies into active duty at period end
// - postscaler never influences pwm period or frequency
// - duty is ten bits: pending byte high, control bits 5:4 low
// - pending duty writable anytime, applied only at period end
// - active duty register is read-only while in pwm mode
// - active byte plus two-bit latch double-buffer the duty
// - pin cleared when active duty equals timer with two fine bits
// - duty beyond period means pin stays high the whole period
// - prescaler divides by one, four or sixteen
// - clearing unit control forces the output latch low
module tbpwm_top
    import tbpwm_pkg::*;
(
    input wire logic ref_clk, // core clock 125 MHz
    input wire logic resetn, // async reset, low active
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    output logic pwm_output_pin_o, // pin output value
    output logic pwm_output_pin_oe // pin output enable
);
    import tbpwm_pkg::*;

    logic [7:0] period_timer_count_reg;
    logic [7:0] period_limit_reg;
    logic [7:0] period_timer_control_reg;
    logic [7:0] duty_pending_upper_reg;
    logic [7:0] duty_active_upper_reg;
    logic [7:0] unit_control_reg;
    logic [1:0] duty_low_latch_reg;
    logic pin_direction_bit_reg;
    logic out_latch_reg;
    logic tick;
    logic [1:0] fine;
    logic timer_run;
    logic pwm_mode;
    logic pwm_active;
    logic period_end;
    logic wr;
    logic rd;
    logic addr_ok;
    logic [9:0] active_duty;
    logic [9:0] pending_duty;
    logic [9:0] timer_ext;
    logic duty_match;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    assign timer_run = period_timer_control_reg[TIMER_RUN_BIT];
    assign pwm_mode = (unit_control_reg[MODE_LSB +: 4] & PWM_MODE_MASK) == PWM_MODE_VALUE;
    assign pwm_active = pwm_mode && timer_run;
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign addr_ok = (paddr == OFF_PERIOD_TIMER_COUNT) || (paddr == OFF_PERIOD_LIMIT) ||
        (paddr == OFF_PERIOD_TIMER_CONTROL) || (paddr == OFF_DUTY_PENDING_UPPER) ||
        (paddr == OFF_DUTY_ACTIVE_UPPER) || (paddr == OFF_UNIT_CONTROL) ||
        (paddr == OFF_PIN_DIRECTION);
    assign pending_duty = {duty_pending_upper_reg, unit_control_reg[DUTY_LOW_LSB +: 2]};
    assign active_duty = {duty_active_upper_reg, duty_low_latch_reg};
    assign timer_ext = {period_timer_count_reg, fine};
    // postscale field is stored but deliberately unused here
    assign period_end = tick && (period_timer_count_reg == period_limit_reg);
    assign duty_match = pwm_active && (active_duty == timer_ext);

    tbpwm_prescaler u_pre (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .run(timer_run),
        .sel(period_timer_control_reg[PRESCALE_LSB +: 2]),
        .tick(tick),
        .fine(fine)
    );

    // ----------------------------------------------------------------
    // apb slave, answers in the access phase with no wait
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            prdata <= 32'h00000000;
        else if (rd)
        begin
            case (paddr)
                OFF_PERIOD_TIMER_COUNT: prdata <= {24'h000000, period_timer_count_reg};
                OFF_PERIOD_LIMIT: prdata <= {24'h000000, period_limit_reg};
                OFF_PERIOD_TIMER_CONTROL: prdata <= {24'h000000, period_timer_control_reg};
                OFF_DUTY_PENDING_UPPER: prdata <= {24'h000000, duty_pending_upper_reg};
                OFF_DUTY_ACTIVE_UPPER: prdata <= {24'h000000, duty_active_upper_reg};
                OFF_UNIT_CONTROL: prdata <= {24'h000000, unit_control_reg};
                OFF_PIN_DIRECTION: prdata <= {31'h00000000, pin_direction_bit_reg};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            period_limit_reg <= RST_LIMIT;
            period_timer_control_reg <= RST_BYTE;
            duty_pending_upper_reg <= RST_BYTE;
            unit_control_reg <= RST_BYTE;
            pin_direction_bit_reg <= RST_DIRECTION[0];
        end
        else if (wr)
        begin
            case (paddr)
                OFF_PERIOD_LIMIT: period_limit_reg <= pwdata[7:0];
                OFF_PERIOD_TIMER_CONTROL: period_timer_control_reg <= {1'b0, pwdata[6:0]};
                OFF_DUTY_PENDING_UPPER: duty_pending_upper_reg <= pwdata[7:0];
                OFF_UNIT_CONTROL: unit_control_reg <= {2'h0, pwdata[5:0]};
                OFF_PIN_DIRECTION: pin_direction_bit_reg <= pwdata[0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // period timer
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            period_timer_count_reg <= RST_BYTE;
        else if (wr && paddr == OFF_PERIOD_TIMER_COUNT)
            period_timer_count_reg <= pwdata[7:0];
        else if (period_end)
            period_timer_count_reg <= 8'h00;
        else if (tick)
            period_timer_count_reg <= period_timer_count_reg + 8'h01;
    end

    // ----------------------------------------------------------------
    // duty double buffer
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            duty_active_upper_reg <= RST_BYTE;
            duty_low_latch_reg <= 2'h0;
        end
        else if (pwm_active && period_end)
        begin
            duty_active_upper_reg <= pending_duty[9:2];
            duty_low_latch_reg <= pending_duty[1:0];
        end
        else if (!pwm_mode && wr && paddr == OFF_DUTY_ACTIVE_UPPER)
            duty_active_upper_reg <= pwdata[7:0];
    end

    // ----------------------------------------------------------------
    // output latch
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            out_latch_reg <= 1'b0;
        else if (unit_control_reg == RST_BYTE)
            out_latch_reg <= 1'b0;
        else if (pwm_active && period_end)
            out_latch_reg <= (pending_duty != 10'h000);
        else if (duty_match)
            out_latch_reg <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pwm_output_pin_o <= 1'b0;
            pwm_output_pin_oe <= 1'b0;
        end
        else
        begin
            // the match cycle itself already counts as low, so no extra high cycle
            pwm_output_pin_o <= out_latch_reg && !duty_match;
            pwm_output_pin_oe <= pwm_mode && !pin_direction_bit_reg;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_timer_clear;
        @(posedge ref_clk) disable iff (!resetn)
        (period_end && !wr) |=> period_timer_count_reg == 8'h00;
    endproperty
    a_timer_clear: assert property (p_timer_clear) else $error("timer not cleared");

    property p_pin_set;
        @(posedge ref_clk) disable iff (!resetn)
        (pwm_active && period_end && unit_control_reg != RST_BYTE && pending_duty != 10'h000)
        |=> ##1 pwm_output_pin_o;
    endproperty
    a_pin_set: assert property (p_pin_set) else $error("pin not set at period start");

    property p_zero_duty;
        @(posedge ref_clk) disable iff (!resetn)
        (pwm_active && period_end && pending_duty == 10'h000) |=> ##1 !pwm_output_pin_o;
    endproperty
    a_zero_duty: assert property (p_zero_duty) else $error("pin set at zero duty");

    property p_latch;
        @(posedge ref_clk) disable iff (!resetn)
        (pwm_active && period_end) |=> active_duty == $past(pending_duty);
    endproperty
    a_latch: assert property (p_latch) else $error("duty not latched");

    property p_hold;
        @(posedge ref_clk) disable iff (!resetn)
        (pwm_mode && !period_end) |=> $stable(active_duty);
    endproperty
    a_hold: assert property (p_hold) else $error("active duty changed mid period");

    property p_ro;
        @(posedge ref_clk) disable iff (!resetn)
        (pwm_mode && wr && paddr == OFF_DUTY_ACTIVE_UPPER && !period_end)
        |=> $stable(duty_active_upper_reg);
    endproperty
    a_ro: assert property (p_ro) else $error("active duty written in pwm mode");

    property p_clear;
        @(posedge ref_clk) disable iff (!resetn)
        (pwm_active && !period_end && unit_control_reg != RST_BYTE && active_duty == timer_ext)
        |=> !pwm_output_pin_o;
    endproperty
    a_clear: assert property (p_clear) else $error("pin not cleared on duty match");

    property p_off;
        @(posedge ref_clk) disable iff (!resetn)
        (unit_control_reg == RST_BYTE) |=> ##1 !pwm_output_pin_o;
    endproperty
    a_off: assert property (p_off) else $error("latch not forced low");

    property p_idle;
        @(posedge ref_clk) disable iff (!resetn)
        (!timer_run) |=> !tick;
    endproperty
    a_idle: assert property (p_idle) else $error("timer ticks while stopped");

    property p_tick_gap;
        @(posedge ref_clk) disable iff (!resetn)
        tick |=> !tick [*3];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("timer steps too fast");

    property p_stay_high;
        @(posedge ref_clk) disable iff (!resetn)
        (out_latch_reg && unit_control_reg != RST_BYTE && !period_end && !duty_match) |=> out_latch_reg;
    endproperty
    a_stay_high: assert property (p_stay_high) else $error("latch fell without match");

    property p_no_set_idle;
        @(posedge ref_clk) disable iff (!resetn)
        !pwm_active |=> !$rose(out_latch_reg);
    endproperty
    a_no_set_idle: assert property (p_no_set_idle) else $error("latch set while idle");

    property p_oe_on;
        @(posedge ref_clk) disable iff (!resetn)
        (pwm_mode && !pin_direction_bit_reg) |=> pwm_output_pin_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("pin not driven in pwm mode");

    property p_oe_off;
        @(posedge ref_clk) disable iff (!resetn)
        pin_direction_bit_reg |=> !pwm_output_pin_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("pin driven with direction set");

    c_period: cover property (@(posedge ref_clk) disable iff (!resetn) pwm_active && period_end);
    c_high: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(pwm_output_pin_o));
    c_low: cover property (@(posedge ref_clk) disable iff (!resetn) $fell(pwm_output_pin_o));
    c_zero: cover property (@(posedge ref_clk) disable iff (!resetn)
        pwm_active && period_end && pending_duty == 10'h000);
endmodule : tbpwm_top
